// file: hw/ssr_start_seq.v
// Purpose: Start profile sequencer: ramp select, kick, ramp, jog, current cap
// Assumes: Operator contacts already debounced and synchronous to clock_i
// Notes: Settings are reached over Avalon-MM; status word at the last offset
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ssr_regs.vh"

// Contract
// - Profile 1..4 picks voltage or current for ramp 1 and ramp 2.
// - Ramp 2 set used only with dual-ramp input closed.
// - Voltage ramp ignores initial current; current ramp ignores initial voltage.
// - Ramp 1 starts at its initial voltage for profiles 1 or 3.
// - Ramp 1 starts at its initial current for profiles 2 or 4.
// - Ramp 1 rises to limit or full voltage over 1..120 s.
// - Ramp may end early once the motor is at full speed.
// - Ramp 1 current capped at its limit until full speed or trip.
// - Ramp 2 starts at its initial voltage for profiles 1 or 4.
// - Ramp 2 starts at its initial current for profiles 2 or 3.
// - Ramp 2 has its own 1..120 s time, same end conditions.
// - Ramp 2 current capped at its own limit until full speed or trip.
// - Jog closed with run holds jog level, no ramp; open ignores jog.
// - Jog by voltage or current following the active ramp type.
// - Voltage jog level programmable 5..100 percent, default 50.
// - Voltage jog ends after its 1..20 s maximum time.
// - Current jog regulated at 100..500 percent with no time limit.
// - Jog disabled when communication port function equals 3.
// - Nonzero kick level applies a voltage pulse before initial torque.
// - Kick pulse never lasts longer than 2 seconds.
// - Kick duration from kick time 0.1..2 s, default 0.8 s.
module ssr_start_seq #(
    parameter TICK_CYCLES = `SSR_TICK_CYCLES
) (
    input wire clock_i,
    input wire rstn_i,
    input wire [5:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [3:0] byteenable_i,
    input wire [31:0] writedata_i,
    output reg [31:0] readdata_o,
    output wire waitrequest_o,
    input wire start_i,
    input wire dual_ramp_i,
    input wire jog_i,
    input wire at_speed_i,
    input wire overload_trip_i,
    input wire [9:0] motor_current_i,
    output reg drive_on_o,
    output reg drive_current_mode_o,
    output reg [9:0] drive_level_o,
    output reg [9:0] current_limit_o,
    output reg limit_active_o,
    output reg ramp2_active_o,
    output reg jog_active_o,
    output reg kick_active_o
);
    localparam ST_IDLE = 3'd0;
    localparam ST_KICK = 3'd1;
    localparam ST_RAMP = 3'd2;
    localparam ST_RUN = 3'd3;
    localparam ST_JOG = 3'd4;
    localparam ST_HOLD = 3'd5;

    localparam IX_PROFILE = 4'd0;
    localparam IX_R1 = 4'd1;
    localparam IX_R2 = 4'd5;
    localparam IX_VJOG_LEVEL = 4'd9;
    localparam IX_VJOG_TIME = 4'd10;
    localparam IX_CJOG_LEVEL = 4'd11;
    localparam IX_KICK_LEVEL = 4'd12;
    localparam IX_KICK_TIME = 4'd13;
    localparam IX_COMM_FUNC = 4'd14;

    // Setting reset value by word index
    function [9:0] cfg_rst;
        input [3:0] ix;
        begin
            case (ix)
                4'd0: cfg_rst = `SSR_RST_PROFILE;
                4'd1, 4'd5: cfg_rst = `SSR_RST_INIT_V;
                4'd2, 4'd6: cfg_rst = `SSR_RST_INIT_I;
                4'd3, 4'd7: cfg_rst = `SSR_RST_TIME;
                4'd4, 4'd8: cfg_rst = `SSR_RST_LIMIT;
                4'd9: cfg_rst = `SSR_RST_VJOG_LEVEL;
                4'd10: cfg_rst = `SSR_RST_VJOG_TIME;
                4'd11: cfg_rst = `SSR_RST_CJOG_LEVEL;
                4'd12: cfg_rst = `SSR_RST_KICK_LEVEL;
                4'd13: cfg_rst = `SSR_RST_KICK_TIME;
                4'd14: cfg_rst = `SSR_RST_COMM_FUNC;
                default: cfg_rst = 10'h000;
            endcase
        end
    endfunction

    // Ramp type: 1 = current ramp, 0 = voltage ramp
    function ramp_is_current;
        input [9:0] profile;
        input sel2;
        begin
            case (profile)
                10'h002: ramp_is_current = 1'b1;
                10'h003: ramp_is_current = sel2;
                10'h004: ramp_is_current = !sel2;
                default: ramp_is_current = 1'b0;
            endcase
        end
    endfunction

    // Seconds to ticks
    function [13:0] sec_ticks;
        input [9:0] sec;
        reg [31:0] p;
        begin
            p = sec * `SSR_TICKS_PER_S;
            sec_ticks = p[13:0];
        end
    endfunction

    reg [9:0] cfg [0:`SSR_NUM_CFG-1];
    reg ack;
    reg [2:0] state;
    reg sel2;
    reg is_cur;
    reg jog_r;
    reg [9:0] init_lvl;
    reg [13:0] time_ticks;
    reg [9:0] limit;
    reg [13:0] tick_cnt;
    reg [9:0] level;
    reg [13:0] acc;
    reg speed_seen;
    reg [9:0] next_level;
    reg next_cur_mode;
    reg next_on;
    reg next_limit_active;
    wire tick;
    wire req = read_i || write_i;
    wire [3:0] ix = address_i[5:2];
    wire mapped = ix < `SSR_NUM_CFG;
    wire take = req && ack;

    // Settings of the ramp about to start
    wire start_sel2 = dual_ramp_i;
    wire [3:0] base = start_sel2 ? IX_R2 : IX_R1;
    wire start_cur = ramp_is_current(cfg[IX_PROFILE], start_sel2);
    wire [9:0] start_init = start_cur ? cfg[base + 4'd1] : cfg[base];
    wire start_jog = jog_i && (cfg[IX_COMM_FUNC] != `SSR_COMM_JOG_OFF);
    wire [13:0] start_time = sec_ticks(cfg[base + 4'd2]);
    wire [9:0] start_limit = cfg[base + 4'd3];

    // Kick duration in ticks, clamped to the two-second ceiling
    wire [31:0] kick_max_w = `SSR_KICK_MAX_TICKS;
    wire [9:0] kick_max = kick_max_w[9:0];
    wire [9:0] kick_raw = cfg[IX_KICK_TIME];
    wire [9:0] kick_clip = (kick_raw > kick_max) ? kick_max : kick_raw;
    wire [13:0] kick_ticks = (kick_clip == 10'h000) ? 14'h0001 : {4'h0, kick_clip};
    wire [13:0] vjog_ticks = sec_ticks(cfg[IX_VJOG_TIME]);

    wire [9:0] final_lvl = is_cur ? limit : `SSR_FULL_VOLTAGE;
    wire [9:0] span = (final_lvl > init_lvl) ? final_lvl - init_lvl : 10'h000;
    wire over_limit = motor_current_i >= limit;

    ssr_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .clear_i(state == ST_IDLE),
        .tick_o(tick)
    );

    // Bus: one wait cycle, then the access completes
    assign waitrequest_o = req && !ack;

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack <= 1'b0;
            readdata_o <= 32'h00000000;
        end else begin
            ack <= req && !ack;
            if (req && !ack && read_i) begin
                if (mapped) begin
                    readdata_o <= {22'h000000, cfg[ix]};
                end else if ({address_i[5:2], 2'b00} == `SSR_OFF_STATUS) begin
                    readdata_o <= {6'h00, level, 8'h00, sel2, is_cur, jog_r,
                        limit_active_o, 1'b0, state};
                end else begin
                    readdata_o <= 32'h00000000;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `SSR_NUM_CFG; g = g + 1) begin : g_cfg
            always @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cfg[g] <= cfg_rst(g);
                end else if (take && write_i && ix == g) begin
                    if (byteenable_i[0]) begin
                        cfg[g][7:0] <= writedata_i[7:0];
                    end
                    if (byteenable_i[1]) begin
                        cfg[g][9:8] <= writedata_i[9:8];
                    end
                end
            end
        end
    endgenerate

    // Sequencer
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            sel2 <= 1'b0;
            is_cur <= 1'b0;
            jog_r <= 1'b0;
            init_lvl <= 10'h000;
            time_ticks <= 14'h0001;
            limit <= 10'h000;
            tick_cnt <= 14'h0000;
            level <= 10'h000;
            acc <= 14'h0000;
            speed_seen <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    tick_cnt <= 14'h0000;
                    acc <= 14'h0000;
                    speed_seen <= 1'b0;
                    if (start_i && !overload_trip_i) begin
                        sel2 <= start_sel2;
                        is_cur <= start_cur;
                        jog_r <= start_jog;
                        init_lvl <= start_init;
                        time_ticks <= (start_time == 14'h0000) ? 14'h0001 : start_time;
                        limit <= start_limit;
                        if (start_jog) begin
                            state <= ST_JOG;
                            level <= start_cur ? cfg[IX_CJOG_LEVEL] : cfg[IX_VJOG_LEVEL];
                        end else if (cfg[IX_KICK_LEVEL] != 10'h000) begin
                            state <= ST_KICK;
                            level <= cfg[IX_KICK_LEVEL];
                        end else begin
                            state <= ST_RAMP;
                            level <= start_init;
                        end
                    end
                end
                ST_KICK: begin
                    if (overload_trip_i) begin
                        state <= ST_HOLD;
                    end else if (!start_i) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        if (tick_cnt + 14'h0001 >= kick_ticks) begin
                            state <= ST_RAMP;
                            level <= init_lvl;
                            tick_cnt <= 14'h0000;
                        end else begin
                            tick_cnt <= tick_cnt + 14'h0001;
                        end
                    end
                end
                ST_RAMP: begin
                    if (overload_trip_i) begin
                        state <= ST_HOLD;
                    end else if (!start_i) begin
                        state <= ST_IDLE;
                    end else if (at_speed_i) begin
                        state <= ST_RUN;
                        speed_seen <= 1'b1;
                    end else if (tick && tick_cnt + 14'h0001 >= time_ticks) begin
                        state <= ST_RUN;
                    end else begin
                        if (tick) begin
                            tick_cnt <= tick_cnt + 14'h0001;
                            acc <= acc + {4'h0, span} - ((acc >= time_ticks) ? time_ticks : 14'h0000);
                        end else if (acc >= time_ticks) begin
                            acc <= acc - time_ticks;
                        end
                        // Spread the span evenly over the ramp time
                        if (acc >= time_ticks && level < final_lvl && (is_cur || !over_limit)) begin
                            level <= level + 10'h001;
                        end
                    end
                end
                ST_RUN: begin
                    level <= `SSR_FULL_VOLTAGE;
                    if (at_speed_i) begin
                        speed_seen <= 1'b1;
                    end
                    if (overload_trip_i) begin
                        state <= ST_HOLD;
                    end else if (!start_i) begin
                        state <= ST_IDLE;
                    end
                end
                ST_JOG: begin
                    if (overload_trip_i) begin
                        state <= ST_HOLD;
                    end else if (!start_i) begin
                        state <= ST_IDLE;
                    end else if (tick && !is_cur) begin
                        if (tick_cnt + 14'h0001 >= vjog_ticks) begin
                            state <= ST_HOLD;
                        end else begin
                            tick_cnt <= tick_cnt + 14'h0001;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!start_i) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Output values for the next cycle
    always @* begin
        next_on = 1'b0;
        next_cur_mode = 1'b0;
        next_level = 10'h000;
        next_limit_active = 1'b0;
        case (state)
            ST_KICK: begin
                next_on = 1'b1;
                next_level = level;
                next_limit_active = 1'b1;
            end
            ST_RAMP: begin
                next_on = 1'b1;
                next_cur_mode = is_cur;
                next_level = level;
                next_limit_active = 1'b1;
            end
            ST_RUN: begin
                next_on = 1'b1;
                next_level = level;
                next_limit_active = !speed_seen;
            end
            ST_JOG: begin
                next_on = 1'b1;
                next_cur_mode = is_cur;
                next_level = level;
                next_limit_active = !is_cur;
            end
            default: begin
                next_on = 1'b0;
            end
        endcase
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drive_on_o <= 1'b0;
            drive_current_mode_o <= 1'b0;
            drive_level_o <= 10'h000;
            current_limit_o <= 10'h000;
            limit_active_o <= 1'b0;
            ramp2_active_o <= 1'b0;
            jog_active_o <= 1'b0;
            kick_active_o <= 1'b0;
        end else begin
            drive_on_o <= next_on;
            drive_current_mode_o <= next_cur_mode;
            drive_level_o <= next_level;
            current_limit_o <= limit;
            limit_active_o <= next_limit_active;
            ramp2_active_o <= sel2 && next_on;
            jog_active_o <= state == ST_JOG;
            kick_active_o <= state == ST_KICK;
        end
    end
endmodule // ssr_start_seq

// file: hw/ssr_regs.vh
// Purpose: Constants for the soft start ramp, jog and kick sequencer
// Assumes: 50 MHz clock, 32-bit Avalon-MM word registers at byte offsets
// Notes: Percent values are plain binary percent; times in seconds or ticks
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// Register byte offsets
`define SSR_OFF_PROFILE 6'h00
`define SSR_OFF_R1_INIT_V 6'h04
`define SSR_OFF_R1_INIT_I 6'h08
`define SSR_OFF_R1_TIME 6'h0c
`define SSR_OFF_R1_LIMIT 6'h10
`define SSR_OFF_R2_INIT_V 6'h14
`define SSR_OFF_R2_INIT_I 6'h18
`define SSR_OFF_R2_TIME 6'h1c
`define SSR_OFF_R2_LIMIT 6'h20
`define SSR_OFF_VJOG_LEVEL 6'h24
`define SSR_OFF_VJOG_TIME 6'h28
`define SSR_OFF_CJOG_LEVEL 6'h2c
`define SSR_OFF_KICK_LEVEL 6'h30
`define SSR_OFF_KICK_TIME 6'h34
`define SSR_OFF_COMM_FUNC 6'h38
`define SSR_OFF_STATUS 6'h3c

// Register word count of the setting array
`define SSR_NUM_CFG 15

// Reset values
`define SSR_RST_PROFILE 10'h001
`define SSR_RST_INIT_V 10'h03c
`define SSR_RST_INIT_I 10'h0c8
`define SSR_RST_TIME 10'h00a
`define SSR_RST_LIMIT 10'h15e
`define SSR_RST_VJOG_LEVEL 10'h032
`define SSR_RST_VJOG_TIME 10'h00a
`define SSR_RST_CJOG_LEVEL 10'h096
`define SSR_RST_KICK_LEVEL 10'h000
`define SSR_RST_KICK_TIME 10'h008
`define SSR_RST_COMM_FUNC 10'h000

// Field positions of the status word
`define SSR_ST_STATE_LSB 0
`define SSR_ST_LIMIT_BIT 4
`define SSR_ST_JOG_BIT 5
`define SSR_ST_CUR_BIT 6
`define SSR_ST_SEL_BIT 7
`define SSR_ST_LEVEL_LSB 16

// Encodings
`define SSR_FULL_VOLTAGE 10'h064
`define SSR_COMM_JOG_OFF 10'h003

// Timing
`define SSR_CLK_KHZ 50000
`define SSR_TICK_MS 100
`define SSR_KICK_MAX_MS 2000
`define SSR_TICK_CYCLES (`SSR_TICK_MS * `SSR_CLK_KHZ)
`define SSR_TICKS_PER_S (1000 / `SSR_TICK_MS)
`define SSR_KICK_MAX_TICKS (`SSR_KICK_MAX_MS / `SSR_TICK_MS)

`endif

// file: hw/ssr_tick.v
// Purpose: Time base pulse for the start sequencer
// Assumes: Clear is a synchronous level that restarts the period
// Notes: One-cycle tick every TICK_CYCLES clocks
`timescale 1ns/1ps
module ssr_tick #(
    parameter TICK_CYCLES = 5000000
) (
    input wire clock_i,
    input wire rstn_i,
    input wire clear_i,
    output reg tick_o
);
    reg [22:0] count;
    wire [31:0] last = TICK_CYCLES - 1;

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= 23'h000000;
            tick_o <= 1'b0;
        end else if (clear_i || count == last[22:0]) begin
            count <= 23'h000000;
            tick_o <= !clear_i;
        end else begin
            count <= count + 23'h000001;
            tick_o <= 1'b0;
        end
    end
endmodule // ssr_tick

// file: tb/ssr_start_seq_props.sv
// Purpose: Port checker for the start sequencer
// Assumes: TICK_CYCLES equals that of the bound instance
// Notes: Kick length counted in clocks
`timescale 1ns/1ps
module ssr_start_seq_props #(
    parameter TICK_CYCLES = 100
) (
    input wire clock_i,
    input wire rstn_i,
    input wire start_i,
    input wire dual_ramp_i,
    input wire overload_trip_i,
    input wire drive_on_o,
    input wire drive_current_mode_o,
    input wire [9:0] drive_level_o,
    input wire [9:0] current_limit_o,
    input wire ramp2_active_o,
    input wire jog_active_o,
    input wire kick_active_o
);
    localparam integer KICK_MAX = 20 * TICK_CYCLES + 2;
    integer kick_n;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            kick_n <= 0;
        end else begin
            kick_n <= kick_active_o ? kick_n + 1 : 0;
        end
    end
    a_kick_voltage: assert property (
        kick_active_o |-> drive_on_o && !drive_current_mode_o) else $error("kick not voltage");
    a_kick_short: assert property (
        kick_n <= KICK_MAX) else $error("kick pulse too long");
    a_start_latency: assert property (
        $rose(start_i) && !overload_trip_i && !drive_on_o |-> ##2 drive_on_o)
        else $error("start not taken");
    a_stop_off: assert property (
        !start_i |-> ##2 !drive_on_o) else $error("drive left on");
    a_trip_off: assert property (
        overload_trip_i |-> ##2 !drive_on_o) else $error("drive on after trip");
    a_current_cap: assert property (
        drive_on_o && drive_current_mode_o && !jog_active_o |-> drive_level_o <= current_limit_o)
        else $error("current above limit");
    a_ramp_select: assert property (
        $rose(drive_on_o) |-> ramp2_active_o == $past(dual_ramp_i, 2))
        else $error("wrong ramp set");
    a_set_held: assert property (
        drive_on_o && $past(drive_on_o) |-> $stable(ramp2_active_o) && $stable(current_limit_o))
        else $error("settings changed mid start");
    a_idle_quiet: assert property (
        !drive_on_o |-> !jog_active_o && !kick_active_o && !ramp2_active_o)
        else $error("flags while off");
endmodule // ssr_start_seq_props

bind ssr_start_seq ssr_start_seq_props #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .clock_i, .rstn_i, .start_i, .dual_ramp_i, .overload_trip_i, .drive_on_o,
    .drive_current_mode_o, .drive_level_o, .current_limit_o, .ramp2_active_o,
    .jog_active_o, .kick_active_o
);

// file: tb/ssr_motor_model.sv
// Purpose: Firing stage and motor sensing model
// Assumes: Load factor scales current in voltage mode
// Notes: One clock of sensing delay
`timescale 1ns/1ps
module ssr_motor_model (
    input wire clock_i,
    input wire on_i,
    input wire cur_mode_i,
    input wire [9:0] level_i,
    input wire [3:0] load_i,
    input wire spin_i,
    output reg [9:0] current_o,
    output reg at_speed_o
);
    initial begin
        current_o = 10'h000;
        at_speed_o = 1'b0;
    end
    always @(posedge clock_i) begin
        at_speed_o <= on_i & spin_i;
        if (!on_i) begin
            current_o <= 10'h000;
        end else if (cur_mode_i) begin
            current_o <= level_i;
        end else begin
            current_o <= level_i * {6'h00, load_i};
        end
    end
endmodule // ssr_motor_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the start sequencer
// Assumes: TICK_CYCLES of 100, one tick is 100 clocks
// Notes: Contacts and trip driven here, motor by the model
`timescale 1ns/1ps
module tb;
    localparam [149:0] DFLT = {10'h000, 10'h008, 10'h000, 10'h096, 10'h00a, 10'h032,
        10'h15e, 10'h00a, 10'h0c8, 10'h03c, 10'h15e, 10'h00a, 10'h0c8, 10'h03c, 10'h001};
    reg clock_i = 1'b0;
    reg rstn_i = 1'b0;
    reg [5:0] address_i = 6'h00;
    reg read_i = 1'b0;
    reg write_i = 1'b0;
    reg [31:0] writedata_i = 32'h00000000;
    reg start_i = 1'b0;
    reg dual_ramp_i = 1'b0;
    reg jog_i = 1'b0;
    reg overload_trip_i = 1'b0;
    reg spin = 1'b0;
    reg [3:0] load = 4'h1;
    integer failures = 0;
    integer checked = 0;
    integer cycles = 0;
    integer n;
    reg [4:0] k;
    reg [2:0] p;
    reg d;
    reg cm;
    reg [9:0] lv;
    reg [9:0] lim;
    wire [31:0] readdata_o;
    wire waitrequest_o;
    wire at_speed_i;
    wire [9:0] motor_current_i;
    wire drive_on_o;
    wire drive_current_mode_o;
    wire [9:0] drive_level_o;
    wire [9:0] current_limit_o;
    wire limit_active_o;
    wire ramp2_active_o;
    wire jog_active_o;
    wire kick_active_o;

    ssr_start_seq #(.TICK_CYCLES(100)) dut_u (
        .clock_i, .rstn_i, .address_i, .read_i, .write_i, .byteenable_i(4'hf),
        .writedata_i, .readdata_o, .waitrequest_o, .start_i, .dual_ramp_i, .jog_i,
        .at_speed_i, .overload_trip_i, .motor_current_i, .drive_on_o, .drive_current_mode_o,
        .drive_level_o, .current_limit_o, .limit_active_o, .ramp2_active_o, .jog_active_o,
        .kick_active_o
    );
    ssr_motor_model mot_u (
        .clock_i, .on_i(drive_on_o), .cur_mode_i(drive_current_mode_o),
        .level_i(drive_level_o), .load_i(load), .spin_i(spin), .current_o(motor_current_i),
        .at_speed_o(at_speed_i)
    );

    always #10 clock_i = ~clock_i;

    task test_done;
        begin
            $display("checked %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            test_done;
        end
    end

    task chk(input string what, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("Error %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task cyc(input integer c);
        repeat (c) @(negedge clock_i);
    endtask

    task bus(input wr, input [5:0] a, input [31:0] dat, output [31:0] q);
        reg w;
        begin
            @(posedge clock_i);
            address_i <= a;
            writedata_i <= dat;
            write_i <= wr;
            read_i <= !wr;
            w = 1'b1;
            while (w) begin
                @(negedge clock_i);
                w = waitrequest_o;
                q = readdata_o;
                @(posedge clock_i);
            end
            read_i <= 1'b0;
            write_i <= 1'b0;
        end
    endtask

    task wr(input [5:0] a, input [9:0] v);
        reg [31:0] q;
        bus(1'b1, a, {22'h000000, v}, q);
    endtask

    task rdc(input [5:0] a, input [31:0] exp);
        reg [31:0] q;
        begin
            bus(1'b0, a, 32'h00000000, q);
            chk("register", q, exp);
        end
    endtask

    task go(input j, input dr);
        integer t;
        begin
            @(posedge clock_i);
            start_i <= 1'b1;
            jog_i <= j;
            dual_ramp_i <= dr;
            t = 0;
            @(negedge clock_i);
            while (drive_on_o !== 1'b1 && t < 50) begin
                @(negedge clock_i);
                t = t + 1;
            end
        end
    endtask

    task stop;
        begin
            @(posedge clock_i);
            start_i <= 1'b0;
            cyc(3);
        end
    endtask

    task outs(input m, input [9:0] l, input [9:0] cl, input r2, input jg, input kk);
        chk("drive", {8'h00, drive_current_mode_o, drive_level_o, current_limit_o,
            ramp2_active_o, jog_active_o, kick_active_o}, {8'h00, m, l, cl, r2, jg, kk});
    endtask

    task kick_len(input integer lo, input integer hi);
        begin
            n = 0;
            while (kick_active_o === 1'b1 && n < 2500) begin
                @(negedge clock_i);
                n = n + 1;
            end
            chk("kick length", {31'h0, n >= lo && n <= hi}, 32'h1);
        end
    endtask

    initial begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        for (k = 0; k < 15; k = k + 1) begin
            rdc({k[3:0], 2'b00}, {22'h000000, DFLT[k * 10 +: 10]});
        end
        $display("settings test done");
        wr(6'h04, 10'h01e);
        wr(6'h08, 10'h078);
        wr(6'h10, 10'h12c);
        wr(6'h14, 10'h028);
        wr(6'h18, 10'h082);
        wr(6'h20, 10'h190);
        rdc(6'h18, 32'h00000082);
        for (p = 1; p <= 4; p = p + 1) begin
            for (n = 0; n < 2; n = n + 1) begin
                d = n[0];
                cm = d ? (p == 2 || p == 3) : (p == 2 || p == 4);
                lv = cm ? (d ? 10'h082 : 10'h078) : (d ? 10'h028 : 10'h01e);
                lim = d ? 10'h190 : 10'h12c;
                wr(6'h00, {7'h00, p});
                go(1'b0, d);
                @(posedge clock_i);
                dual_ramp_i <= !d;
                cyc(2);
                outs(cm, lv, lim, d, 1'b0, 1'b0);
                stop;
            end
        end
        $display("profile test done");
        wr(6'h00, 10'h003);
        wr(6'h24, 10'h02d);
        wr(6'h28, 10'h001);
        go(1'b1, 1'b1);
        outs(1'b1, 10'h096, 10'h190, 1'b1, 1'b1, 1'b0);
        rdc(6'h3c, 32'h009600e4);
        cyc(1500);
        chk("current jog", {31'h0, drive_on_o}, 32'h1);
        stop;
        go(1'b1, 1'b0);
        outs(1'b0, 10'h02d, 10'h12c, 1'b0, 1'b1, 1'b0);
        n = 0;
        while (drive_on_o === 1'b1 && n < 1300) begin
            @(negedge clock_i);
            n = n + 1;
        end
        chk("voltage jog time", {31'h0, n >= 950 && n <= 1050}, 32'h1);
        stop;
        wr(6'h38, 10'h003);
        go(1'b1, 1'b0);
        outs(1'b0, 10'h01e, 10'h12c, 1'b0, 1'b0, 1'b0);
        stop;
        wr(6'h38, 10'h000);
        $display("jog test done");
        wr(6'h00, 10'h002);
        wr(6'h30, 10'h050);
        wr(6'h34, 10'h003);
        go(1'b0, 1'b0);
        outs(1'b0, 10'h050, 10'h12c, 1'b0, 1'b0, 1'b1);
        kick_len(250, 350);
        outs(1'b1, 10'h078, 10'h12c, 1'b0, 1'b0, 1'b0);
        stop;
        wr(6'h00, 10'h001);
        wr(6'h34, 10'h01e);
        go(1'b0, 1'b0);
        kick_len(1950, 2050);
        stop;
        wr(6'h30, 10'h000);
        $display("kick test done");
        wr(6'h0c, 10'h001);
        go(1'b0, 1'b0);
        cyc(500);
        n = drive_level_o > 10'h01e && drive_level_o < 10'h064;
        chk("ramp rising", n, 32'h1);
        @(posedge clock_i);
        spin <= 1'b1;
        cyc(6);
        chk("at speed", {20'h0, drive_level_o, limit_active_o, drive_current_mode_o},
            {20'h0, 10'h064, 2'b00});
        stop;
        @(posedge clock_i);
        spin <= 1'b0;
        load <= 4'hf;
        go(1'b0, 1'b0);
        cyc(500);
        chk("capped", {21'h0, drive_level_o, limit_active_o}, {21'h0, 10'h01e, 1'b1});
        @(posedge clock_i);
        overload_trip_i <= 1'b1;
        cyc(3);
        chk("trip", {31'h0, drive_on_o}, 32'h0);
        stop;
        @(posedge clock_i);
        overload_trip_i <= 1'b0;
        load <= 4'h1;
        wr(6'h1c, 10'h002);
        go(1'b0, 1'b1);
        cyc(1500);
        n = drive_level_o > 10'h028 && drive_level_o < 10'h064;
        chk("ramp2 time", n, 32'h1);
        cyc(600);
        chk("ramp2 end", {21'h0, drive_level_o, limit_active_o}, {21'h0, 10'h064, 1'b1});
        stop;
        $display("ramp test done");
        test_done;
    end
endmodule // tb
